// >>> hw/tuning_regs.sv
// Per-bank register page for tunable transmitter lanes
`timescale 1ns/1ps
module tuning_regs
   import tuning_pkg::*;
#(
   parameter logic [7:0]         BANK_INDEX = 8'h00,
   parameter logic signed [15:0] FINE_MIN   = -16'sd6000,
   parameter logic signed [15:0] FINE_MAX   = 16'sd6000,
   parameter logic signed [15:0] POWER_MIN  = -16'sd1000,
   parameter logic signed [15:0] POWER_MAX  = 16'sd1000
) (
   input  wire logic                       CLK,
   input  wire logic                       RESET,
   input  wire logic [7:0]                 PAGE_BANK,
   input  wire logic [7:0]                 ADDR,
   input  wire logic                       WR_EN,
   input  wire logic [7:0]                 WR_DATA,
   input  wire logic                       RD_EN,
   output logic      [7:0]                 RD_DATA,
   output logic                            RD_VALID,
   input  wire logic [LANES-1:0][31:0]     PRESENT_FREQ,
   input  wire logic [LANES-1:0]           TUNE_BUSY,
   output lane_cfg_s [LANES-1:0]           LANE_CFG,
   output logic      [LANES-1:0]           CFG_UPDATE,
   output logic      [LANES-1:0]           FLAG_ROLLUP,
   output logic                            ALERT,
   output logic                            PAGE_SUPPORTED
);

   localparam int LW = $clog2(LANES);

   logic            hit;
   logic            wr;
   logic            rd;
   logic [7:0]      off_grid;
   logic [7:0]      off_chan;
   logic [7:0]      off_fine;
   logic [7:0]      off_freq;
   logic [7:0]      off_power;
   logic [7:0]      off_status;
   logic [7:0]      off_flags;
   logic [7:0]      off_masks;
   logic            in_grid;
   logic            in_chan;
   logic            in_fine;
   logic            in_freq;
   logic            in_power;
   logic            in_status;
   logic            in_rollup;
   logic            in_flags;
   logic            in_masks;
   logic            in_word;
   logic [7:0]      word_off;
   logic [LW-1:0]   word_lane;
   logic [LW-1:0]   byte_lane;
   logic [LW-1:0]   freq_lane;

   logic [3:0]      grid_step [LANES];
   logic [LANES-1:0] fine_on;
   logic [15:0]     chan      [LANES];
   logic [15:0]     fine      [LANES];
   logic [15:0]     power     [LANES];

   logic            stage_valid;
   logic [7:0]      stage_addr;
   logic [7:0]      stage_byte;
   logic            commit;
   logic [15:0]     commit_word;
   logic            fine_bad;
   logic            power_bad;

   logic [7:0]      flags     [LANES];
   logic [7:0]      mask      [LANES];
   logic [LANES-1:0] alert_vec;
   logic [LANES-1:0] clr_vec;
   logic [LANES-1:0] mask_wr_vec;
   logic [LANES-1:0] set_power_vec;
   logic [LANES-1:0] set_fine_vec;
   logic [7:0]      freq_byte;
   logic [7:0]      next_rd_data;

   // Only the selected bank of eight lanes decodes accesses; a read of another bank is still answered, with zero
   assign hit = (PAGE_BANK == BANK_INDEX);
   assign wr  = WR_EN & hit;
   assign rd  = RD_EN & hit;

   // Region decode; everything outside reads zero and ignores writes
   always_comb begin
      off_grid   = ADDR - OFS_GRID;
      off_chan   = ADDR - OFS_CHAN;
      off_fine   = ADDR - OFS_FINE;
      off_freq   = ADDR - OFS_FREQ;
      off_power  = ADDR - OFS_POWER;
      off_status = ADDR - OFS_STATUS;
      off_flags  = ADDR - OFS_FLAGS;
      off_masks  = ADDR - OFS_MASKS;
      in_grid    = (ADDR >= OFS_GRID)   && (ADDR < OFS_CHAN);
      in_chan    = (ADDR >= OFS_CHAN)   && (ADDR < OFS_FINE);
      in_fine    = (ADDR >= OFS_FINE)   && (ADDR < OFS_FREQ);
      in_freq    = (ADDR >= OFS_FREQ)   && (ADDR < OFS_POWER);
      in_power   = (ADDR >= OFS_POWER)  && (ADDR < OFS_RSV_A);
      in_status  = (ADDR >= OFS_STATUS) && (ADDR < OFS_ROLLUP);
      in_rollup  = (ADDR == OFS_ROLLUP);
      in_flags   = (ADDR >= OFS_FLAGS)  && (ADDR < OFS_MASKS);
      in_masks   = (ADDR >= OFS_MASKS)  && (ADDR < OFS_RSV_B);
      in_word    = in_chan | in_fine | in_power;
      word_off   = in_chan ? off_chan : (in_fine ? off_fine : off_power);
      // Lowest address of each array belongs to lane 0
      word_lane  = word_off[LW:1];
      freq_lane  = off_freq[LW+1:2];
      byte_lane  = in_grid ? off_grid[LW-1:0] :
                   (in_status ? off_status[LW-1:0] :
                   (in_flags ? off_flags[LW-1:0] : off_masks[LW-1:0]));
   end

   // High byte at the even address is staged, the odd byte commits both
   always_ff @(posedge CLK) begin
      if (RESET) begin
         stage_valid <= 1'b0;
         stage_addr  <= ZERO_BYTE;
         stage_byte  <= ZERO_BYTE;
      end else if (wr) begin
         stage_valid <= in_word & ~word_off[0];
         stage_addr  <= ADDR;
         stage_byte  <= WR_DATA;
      end
   end

   always_comb begin
      commit      = wr & in_word & word_off[0] & stage_valid
                    & (stage_addr == (ADDR - 8'h01));
      commit_word = {stage_byte, WR_DATA};
      fine_bad    = ($signed(commit_word) < FINE_MIN)  || ($signed(commit_word) > FINE_MAX);
      power_bad   = ($signed(commit_word) < POWER_MIN) || ($signed(commit_word) > POWER_MAX);
   end

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gen_lane

         // Reserved grid codes are refused, bits 3-1 never stored
         always_ff @(posedge CLK) begin
            if (RESET) begin
               grid_step[g] <= GRID_RST;
               fine_on[g]   <= 1'b0;
            end else if (wr && in_grid && byte_lane == LW'(g)) begin
               if (!(WR_DATA[7:4] >= GRID_RSV_MIN && WR_DATA[7:4] <= GRID_RSV_MAX)) begin
                  grid_step[g] <= WR_DATA[7:4];
               end
               fine_on[g] <= WR_DATA[FINE_ON_BIT];
            end
         end

         always_ff @(posedge CLK) begin
            if (RESET) begin
               chan[g] <= WORD_RST;
            end else if (commit && in_chan && word_lane == LW'(g)) begin
               chan[g] <= commit_word;
            end
         end

         // Out-of-range values are kept out of the control loop
         always_ff @(posedge CLK) begin
            if (RESET) begin
               fine[g] <= WORD_RST;
            end else if (commit && in_fine && word_lane == LW'(g) && !fine_bad) begin
               fine[g] <= commit_word;
            end
         end

         always_ff @(posedge CLK) begin
            if (RESET) begin
               power[g] <= WORD_RST;
            end else if (commit && in_power && word_lane == LW'(g) && !power_bad) begin
               power[g] <= commit_word;
            end
         end

         always_ff @(posedge CLK) begin
            if (RESET) begin
               CFG_UPDATE[g] <= 1'b0;
            end else begin
               CFG_UPDATE[g] <= (wr && in_grid && byte_lane == LW'(g))
                                || (commit && word_lane == LW'(g));
            end
         end

         always_comb begin
            LANE_CFG[g].grid_step        = grid_step[g];
            LANE_CFG[g].fine_adjust_on   = fine_on[g];
            LANE_CFG[g].channel_index    = chan[g];
            LANE_CFG[g].fine_freq_offset = fine[g];
            LANE_CFG[g].power_target     = power[g];
         end

         assign set_power_vec[g] = commit & in_power & (word_lane == LW'(g)) & power_bad;
         assign set_fine_vec[g]  = commit & in_fine & (word_lane == LW'(g)) & fine_bad;
         assign clr_vec[g]       = rd & in_flags & (byte_lane == LW'(g));
         assign mask_wr_vec[g]   = wr & in_masks & (byte_lane == LW'(g));

         lane_flag_cell u_flag (
            .clk           (CLK),
            .rst           (RESET),
            .set_power_err (set_power_vec[g]),
            .set_fine_err  (set_fine_vec[g]),
            .clear         (clr_vec[g]),
            .mask_wr       (mask_wr_vec[g]),
            .mask_data     (WR_DATA),
            .flags         (flags[g]),
            .mask          (mask[g]),
            .rollup        (FLAG_ROLLUP[g]),
            .alert         (alert_vec[g])
         );
      end
   endgenerate

   freq_snapshot #(
      .LANES_N (LANES)
   ) u_snap (
      .clk      (CLK),
      .rst      (RESET),
      .capture  (rd && in_freq && off_freq[1:0] == 2'h0),
      .lane     (freq_lane),
      .byte_sel (off_freq[1:0]),
      .freq     (PRESENT_FREQ),
      .rd_byte  (freq_byte)
   );

   // Read mux; multi-byte words are sent most significant byte first
   always_comb begin
      next_rd_data = ZERO_BYTE;
      if (in_grid) begin
         next_rd_data[7:4]         = grid_step[byte_lane];
         next_rd_data[FINE_ON_BIT] = fine_on[byte_lane];
      end else if (in_chan) begin
         next_rd_data = word_off[0] ? chan[word_lane][7:0] : chan[word_lane][15:8];
      end else if (in_fine) begin
         next_rd_data = word_off[0] ? fine[word_lane][7:0] : fine[word_lane][15:8];
      end else if (in_freq) begin
         next_rd_data = freq_byte;
      end else if (in_power) begin
         next_rd_data = word_off[0] ? power[word_lane][7:0] : power[word_lane][15:8];
      end else if (in_status) begin
         next_rd_data[TUNE_ACTIVE_BIT] = TUNE_BUSY[byte_lane];
      end else if (in_rollup) begin
         next_rd_data = FLAG_ROLLUP;
      end else if (in_flags) begin
         next_rd_data = flags[byte_lane];
      end else if (in_masks) begin
         next_rd_data = mask[byte_lane];
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RD_DATA  <= ZERO_BYTE;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
         if (rd) begin
            RD_DATA <= next_rd_data;
         end else if (RD_EN) begin
            RD_DATA <= ZERO_BYTE;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ALERT          <= 1'b0;
         PAGE_SUPPORTED <= 1'b0;
      end else begin
         ALERT          <= |alert_vec;
         PAGE_SUPPORTED <= 1'b1;
      end
   end

endmodule

// >>> inc/tuning_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the laser tuning page
package tuning_pkg;

   localparam int LANES = 8;

   // Byte offsets on the page
   localparam logic [7:0] OFS_GRID   = 8'h80;
   localparam logic [7:0] OFS_CHAN   = 8'h88;
   localparam logic [7:0] OFS_FINE   = 8'h98;
   localparam logic [7:0] OFS_FREQ   = 8'hA8;
   localparam logic [7:0] OFS_POWER  = 8'hC8;
   localparam logic [7:0] OFS_RSV_A  = 8'hD8;
   localparam logic [7:0] OFS_STATUS = 8'hDE;
   localparam logic [7:0] OFS_ROLLUP = 8'hE6;
   localparam logic [7:0] OFS_FLAGS  = 8'hE7;
   localparam logic [7:0] OFS_MASKS  = 8'hEF;
   localparam logic [7:0] OFS_RSV_B  = 8'hF7;

   // Field positions
   localparam int GRID_STEP_LSB   = 4;
   localparam int FINE_ON_BIT     = 0;
   localparam int TUNE_ACTIVE_BIT = 1;
   localparam int POWER_ERR_BIT   = 5;
   localparam int FINE_ERR_BIT    = 4;

   // Grid spacing codes
   localparam logic [3:0] GRID_3G125   = 4'h0;
   localparam logic [3:0] GRID_6G25    = 4'h1;
   localparam logic [3:0] GRID_12G5    = 4'h2;
   localparam logic [3:0] GRID_25G     = 4'h3;
   localparam logic [3:0] GRID_50G     = 4'h4;
   localparam logic [3:0] GRID_100G    = 4'h5;
   localparam logic [3:0] GRID_33G     = 4'h6;
   localparam logic [3:0] GRID_75G     = 4'h7;
   localparam logic [3:0] GRID_RSV_MIN = 4'h8;
   localparam logic [3:0] GRID_RSV_MAX = 4'hE;
   localparam logic [3:0] GRID_NA      = 4'hF;

   // Reset values
   localparam logic [3:0]  GRID_RST = GRID_3G125;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [7:0]  MASK_RST = 8'hFF;
   localparam logic [7:0]  FLAG_RST = 8'h00;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;

   // Settings handed to the laser control loop, one per lane
   typedef struct packed {
      logic [3:0]  grid_step;
      logic        fine_adjust_on;
      logic [15:0] channel_index;
      logic [15:0] fine_freq_offset;
      logic [15:0] power_target;
   } lane_cfg_s;

endpackage

// >>> hw/freq_snapshot.sv
// One capture register, shared by all lanes, holds the 32-bit present frequency so multi-byte reads stay coherent
`timescale 1ns/1ps
module freq_snapshot
   import tuning_pkg::*;
#(
   parameter int LANES_N = LANES
) (
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             capture,
   input  wire logic [$clog2(LANES_N)-1:0]       lane,
   input  wire logic [1:0]                       byte_sel,
   input  wire logic [LANES_N-1:0][31:0]         freq,
   output logic      [7:0]                       rd_byte
);

   logic [31:0] snap;
   logic [31:0] word;

   // First byte read freezes the whole word of that lane
   always_ff @(posedge clk) begin
      if (rst) begin
         snap <= 32'h0000_0000;
      end else if (capture) begin
         snap <= freq[lane];
      end
   end

   // Most significant byte sits at the lowest address
   always_comb begin
      word = capture ? freq[lane] : snap;
      case (byte_sel)
         2'h0:    rd_byte = word[31:24];
         2'h1:    rd_byte = word[23:16];
         2'h2:    rd_byte = word[15:8];
         default: rd_byte = word[7:0];
      endcase
   end

endmodule

// >>> hw/lane_flag_cell.sv
// Latched clear-on-read flags and mask byte of one lane
`timescale 1ns/1ps
module lane_flag_cell
   import tuning_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       set_power_err,
   input  wire logic       set_fine_err,
   input  wire logic       clear,
   input  wire logic       mask_wr,
   input  wire logic [7:0] mask_data,
   output logic      [7:0] flags,
   output logic      [7:0] mask,
   output logic            rollup,
   output logic            alert
);

   logic [7:0] set_vec;

   always_comb begin
      set_vec = FLAG_RST;
      set_vec[POWER_ERR_BIT] = set_power_err;
      set_vec[FINE_ERR_BIT]  = set_fine_err;
   end

   // A flag raised in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= FLAG_RST;
      end else begin
         flags <= (flags & ~{8{clear}}) | set_vec;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask <= MASK_RST;
      end else if (mask_wr) begin
         mask <= mask_data;
      end
   end

   assign rollup = |flags;
   assign alert  = |(flags & ~mask);

endmodule

// >>> bench/tuning_regs_assertions.sv
// Port-level checks of the tuning page register bank
`timescale 1ns/1ps
module tuning_regs_assertions
   import tuning_pkg::*;
#(
   parameter logic [7:0] BANK_INDEX = 8'h00
) (
   input  wire logic                   CLK,
   input  wire logic                   RESET,
   input  wire logic [7:0]             PAGE_BANK,
   input  wire logic [7:0]             ADDR,
   input  wire logic                   WR_EN,
   input  wire logic [7:0]             WR_DATA,
   input  wire logic                   RD_EN,
   input  wire logic [7:0]             RD_DATA,
   input  wire logic                   RD_VALID,
   input  wire logic [LANES-1:0]       TUNE_BUSY,
   input  wire lane_cfg_s [LANES-1:0]  LANE_CFG,
   input  wire logic [LANES-1:0]       CFG_UPDATE,
   input  wire logic [LANES-1:0]       FLAG_ROLLUP,
   input  wire logic                   PAGE_SUPPORTED
);
   logic sel;
   logic busy_sel;
   logic rsv;
   assign sel = PAGE_BANK == BANK_INDEX;
   assign rsv = ADDR >= OFS_RSV_A && ADDR < OFS_STATUS;
   // Busy bit of the lane addressed now, for the answer one cycle later
   always_ff @(posedge CLK) begin
      busy_sel <= TUNE_BUSY[3'(ADDR - OFS_STATUS)];
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   read_answer_a: assert property (RD_EN |=> RD_VALID)
      else $error("read not answered one cycle later");
   answer_pulse_a: assert property (!RD_EN |=> !RD_VALID)
      else $error("read answer without a read");
   reserved_read_a: assert property (RD_EN && rsv |=> RD_DATA == 8'h00)
      else $error("reserved byte read not zero");
   bank_read_a: assert property (RD_EN && !sel |=> RD_DATA == 8'h00)
      else $error("other bank read not zero");
   status_read_a: assert property (RD_EN && sel && ADDR >= OFS_STATUS && ADDR < OFS_ROLLUP
      |=> RD_DATA == {6'h00, busy_sel, 1'b0})
      else $error("status byte does not show lane busy");
   rollup_read_a: assert property (RD_EN && sel && ADDR == OFS_ROLLUP
      |=> RD_DATA == $past(FLAG_ROLLUP))
      else $error("rollup byte differs from rollup lines");
   page_flag_a: assert property (!$past(RESET) |-> PAGE_SUPPORTED)
      else $error("page support not advertised");
   grid_write_a: assert property (WR_EN && sel && ADDR[7:3] == 5'h10
      |=> CFG_UPDATE[$past(ADDR[2:0])]
      && LANE_CFG[$past(ADDR[2:0])].fine_adjust_on == $past(WR_DATA[0]))
      else $error("grid write not applied to its lane");
   word_update_a: assert property (WR_EN && sel && $past(WR_EN && sel) && ADDR[0]
      && ((ADDR >= OFS_CHAN && ADDR < OFS_FREQ) || (ADDR >= OFS_POWER && ADDR < OFS_RSV_A))
      && $past(ADDR) == ADDR - 8'h01 |=> $countones(CFG_UPDATE) == 1)
      else $error("word commit gave no single lane update pulse");
   quiet_update_a: assert property (!(WR_EN && sel) |=> CFG_UPDATE == 8'h00)
      else $error("update pulse without a write");
   reserved_write_a: assert property (WR_EN && rsv |=> $stable(LANE_CFG))
      else $error("reserved write changed settings");
   stable_cfg_a: assert property (!WR_EN |=> $stable(LANE_CFG))
      else $error("settings changed without a write");
endmodule
bind tuning_regs tuning_regs_assertions #(.BANK_INDEX(BANK_INDEX)) tuning_regs_assertions_i (
   .CLK(CLK), .RESET(RESET), .PAGE_BANK(PAGE_BANK), .ADDR(ADDR), .WR_EN(WR_EN),
   .WR_DATA(WR_DATA), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
   .TUNE_BUSY(TUNE_BUSY), .LANE_CFG(LANE_CFG), .CFG_UPDATE(CFG_UPDATE),
   .FLAG_ROLLUP(FLAG_ROLLUP), .PAGE_SUPPORTED(PAGE_SUPPORTED));

// >>> bench/host_model.sv
// Host management controller model driving the byte bus of the page
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk,
   input  wire logic       page_ok,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output logic      [7:0] addr,
   output logic            wr_en,
   output logic      [7:0] wr_data,
   output logic            rd_en
);
   initial begin
      addr = 8'h00;
      wr_en = 1'b0;
      wr_data = 8'h00;
      rd_en = 1'b0;
   end
   // Each access waits up to 50 cycles for the page to advertise support
   task automatic ready;
      for (int n = 0; n < 50 && page_ok !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
   endtask
   // Write strobe stays up so a word can go out back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ready();
      addr = a;
      wr_data = d;
      rd_en = 1'b0;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      ready();
      addr = a;
      wr_en = 1'b0;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      r = {rd_valid, rd_data};
      rd_en = 1'b0;
      addr = ~addr;
      @(posedge clk);
      #1;
   endtask
   // Released bus shows a changed value, not the last one
   task automatic idle;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_data = ~wr_data;
      @(posedge clk);
      #1;
   endtask
endmodule

// >>> bench/tb_tuning_regs.sv
// Self-checking bench for the tuning page register bank
`timescale 1ns/1ps
module tb_tuning_regs;
   import tuning_pkg::*;
   logic                  CLK, RESET, WR_EN, RD_EN, RD_VALID, ALERT, PAGE_SUPPORTED;
   logic [7:0]            PAGE_BANK, ADDR, WR_DATA, RD_DATA, d, g, a;
   logic [LANES-1:0]      TUNE_BUSY, CFG_UPDATE, FLAG_ROLLUP;
   logic [LANES-1:0][31:0] PRESENT_FREQ;
   lane_cfg_s [LANES-1:0] LANE_CFG;
   logic [8:0]            r;
   logic [15:0]           w;
   logic [31:0]           f;
   int                    n_errors = 0;
   int                    num_checks = 0;
   int                    l, j;
   int                    lim [3] = '{32767, 6000, 1000};
   logic [7:0]            base [3] = '{OFS_CHAN, OFS_FINE, OFS_POWER};
   tuning_regs tuning_regs_i (.CLK(CLK), .RESET(RESET), .PAGE_BANK(PAGE_BANK), .ADDR(ADDR),
      .WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
      .RD_VALID(RD_VALID), .PRESENT_FREQ(PRESENT_FREQ), .TUNE_BUSY(TUNE_BUSY),
      .LANE_CFG(LANE_CFG), .CFG_UPDATE(CFG_UPDATE), .FLAG_ROLLUP(FLAG_ROLLUP),
      .ALERT(ALERT), .PAGE_SUPPORTED(PAGE_SUPPORTED));
   host_model host_model_i (.clk(CLK), .page_ok(PAGE_SUPPORTED), .rd_data(RD_DATA),
      .rd_valid(RD_VALID), .addr(ADDR), .wr_en(WR_EN), .wr_data(WR_DATA), .rd_en(RD_EN));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdc(input string what, input logic [7:0] ad, input logic [7:0] exp);
      host_model_i.rd(ad, r);
      chk(what, {23'h0, 1'b1, exp}, {23'h0, r});
   endtask
   task automatic wword(input logic [7:0] ad, input logic [15:0] v);
      host_model_i.wr(ad, v[15:8]);
      host_model_i.wr(ad + 8'h01, v[7:0]);
      host_model_i.idle();
   endtask
   function automatic logic [15:0] fld(input int k, input int n);
      case (k)
         0: return LANE_CFG[n].channel_index;
         1: return LANE_CFG[n].fine_freq_offset;
         default: return LANE_CFG[n].power_target;
      endcase
   endfunction
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   initial begin
      #200000;
      n_errors++;
      close_out();
   end
   initial begin
      RESET = 1'b1;
      PAGE_BANK = 8'h00;
      PRESENT_FREQ = '0;
      TUNE_BUSY = 8'h00;
      void'($urandom(20701));
      repeat (12) @(posedge CLK);
      #1;
      RESET = 1'b0;
      for (l = 0; l < LANES; l++) begin
         rdc("mask", OFS_MASKS + 8'(l), MASK_RST);
         rdc("grid", OFS_GRID + 8'(l), 8'h00);
      end
      l = $urandom_range(LANES - 1);
      g = 8'h00;
      for (int c = 0; c < 16; c++) begin
         d = {4'(c), 3'($urandom), 1'($urandom)};
         if (c < 8 || c == 15) g[7:4] = 4'(c);
         g[0] = d[0];
         host_model_i.wr(OFS_GRID + 8'(l), d);
         host_model_i.idle();
         chk("cfg", {g[7:4], g[0]}, {LANE_CFG[l].grid_step, LANE_CFG[l].fine_adjust_on});
         rdc("grid", OFS_GRID + 8'(l), g);
      end
      for (int k = 0; k < 30; k++) begin
         j = k % 3;
         l = $urandom_range(LANES - 1);
         a = base[j] + 8'(2 * l);
         w = 16'(int'($urandom_range(2 * lim[j])) - lim[j]);
         wword(a, w);
         chk("word", w, fld(j, l));
         rdc("msb", a, w[15:8]);
         rdc("lsb", a + 8'h01, w[7:0]);
         if (j > 0) begin
            // Either side of the allowed span must be refused
            wword(a, 16'(($urandom_range(1) ? 1 : -1) * (lim[j] + 1 + int'($urandom_range(99)))));
            chk("kept", w, fld(j, l));
            chk("alert", 0, ALERT);
            rdc("rollup", OFS_ROLLUP, 8'(1 << l));
            rdc("flags", OFS_FLAGS + 8'(l), 8'(1 << (j + 3)));
            rdc("cleared", OFS_FLAGS + 8'(l), 8'h00);
         end
      end
      wword(OFS_CHAN, 16'h1234);
      host_model_i.wr(OFS_CHAN + 8'h01, 8'hA5);
      host_model_i.idle();
      chk("lone", 16'h1234, LANE_CFG[0].channel_index);
      for (l = 0; l < LANES; l++) begin
         PRESENT_FREQ[l] = $urandom;
      end
      TUNE_BUSY = 8'($urandom);
      for (l = 0; l < LANES; l++) begin
         f = PRESENT_FREQ[l];
         for (int b = 0; b < 4; b++) begin
            rdc("freq", OFS_FREQ + 8'(4 * l + b), f[31 - 8 * b -: 8]);
            PRESENT_FREQ[l] = ~f;
         end
         rdc("busy", OFS_STATUS + 8'(l), {6'h00, TUNE_BUSY[l], 1'b0});
      end
      foreach (base[i]) begin
         a = i == 0 ? OFS_RSV_A : (i == 1 ? OFS_RSV_B : 8'hFF);
         host_model_i.wr(a, 8'hFF);
         host_model_i.idle();
         rdc("reserved", a, 8'h00);
      end
      PAGE_BANK = 8'h01;
      host_model_i.wr(OFS_MASKS, 8'h00);
      host_model_i.idle();
      rdc("other bank", OFS_MASKS, 8'h00);
      PAGE_BANK = 8'h00;
      rdc("own bank", OFS_MASKS, MASK_RST);
      host_model_i.wr(OFS_MASKS, 8'h00);
      wword(OFS_POWER, 16'h7000);
      host_model_i.idle();
      chk("alert on", 1, ALERT);
      rdc("flags", OFS_FLAGS, 8'h20);
      host_model_i.idle();
      chk("alert off", 0, ALERT);
      close_out();
   end
endmodule
